// file: asc_map.vh
`ifndef ASC_MAP_VH
`define ASC_MAP_VH
// geometry of the external memory
`define ASC_ADDR_W 13
`define ASC_DATA_W 8
// timing figures in ns, clock period in ns
`define ASC_CLK_NS 50
`define ASC_TWP_NS 25
`define ASC_TWHZ_NS 14
`define ASC_TDW_NS 15
`define ASC_TAA_NS 35
`define ASC_TWR2_NS 5
// least time in cycles, rounded up, never below one
`define ASC_CYC(ns) ((((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS) < 1 ? 1 : \
    (((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS))
// one-hot state codes
`define ASC_S_IDLE 6'h01
`define ASC_S_RSEL 6'h02
`define ASC_S_RCAP 6'h04
`define ASC_S_WSEL 6'h08
`define ASC_S_WPUL 6'h10
`define ASC_S_WEND 6'h20
`define ASC_CNT_W 4
`define ASC_CNT_ZERO 4'h0
`define ASC_CNT_ONE 4'h1
// extra read wait for the two synchroniser flops
`define ASC_SYNC_STAGES 4'h2
`endif

// file: asc_sync.v
// two-stage synchroniser for the data pins coming back from the memory
module asc_sync #(
    parameter W = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // raw and synchronised data
    input wire [W-1:0] d_in,
    output reg [W-1:0] d_out
);
    reg [W-1:0] meta_r; // first stage, read only by the second
    // both stages clear under reset
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= {W{1'b0}};
            d_out <= {W{1'b0}};
        end
        else
        begin
            meta_r <= d_in;
            d_out <= meta_r;
        end
    end
endmodule // asc_sync

// file: asc_ctrl.v
// Behaviour
// - write strobe kept high during reads
// - address moves only with strobe or selects off
// - no write data while memory still drives
// - strobe low covers turn-off plus data overlap
// - output enable high allows minimum pulse
`include "asc_map.vh"

module asc_ctrl #(
    parameter AW = `ASC_ADDR_W,
    parameter DW = `ASC_DATA_W
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // user request side
    input wire req_valid,
    input wire req_write,
    input wire [AW-1:0] req_addr,
    input wire [DW-1:0] req_wdata,
    output reg req_ready,
    output reg rd_valid,
    output reg [DW-1:0] rd_data,
    // memory pins
    output reg [AW-1:0] mem_addr,
    output reg active_low_select_n,
    output reg active_high_select,
    output reg mem_we_n,
    output reg mem_oe_n,
    input wire [DW-1:0] mem_dq_in,
    output reg [DW-1:0] mem_dq_out,
    output reg mem_dq_oe
);
    // cycle counts from ns figures, rounded up to whole clocks
    localparam integer WP_N = `ASC_CYC(`ASC_TWP_NS);
    localparam integer RD_N = `ASC_CYC(`ASC_TAA_NS);
    localparam integer WR_N = `ASC_CYC(`ASC_TWR2_NS);
    // oe held high in writes, so twp alone sets the pulse
    localparam [`ASC_CNT_W-1:0] WP_CYC = WP_N[`ASC_CNT_W-1:0];
    // read wait: access time plus two synchroniser stages
    localparam [`ASC_CNT_W-1:0] RD_CYC = RD_N[`ASC_CNT_W-1:0] +
        `ASC_SYNC_STAGES;
    // write data kept driven a little after the strobe rises
    localparam [`ASC_CNT_W-1:0] WR_CYC = WR_N[`ASC_CNT_W-1:0];
    localparam [5:0] S_IDLE = `ASC_S_IDLE;
    localparam [5:0] S_RSEL = `ASC_S_RSEL;
    localparam [5:0] S_RCAP = `ASC_S_RCAP;
    localparam [5:0] S_WSEL = `ASC_S_WSEL;
    localparam [5:0] S_WPUL = `ASC_S_WPUL;
    localparam [5:0] S_WEND = `ASC_S_WEND;

    reg [5:0] state_r; // one-hot state
    reg [`ASC_CNT_W-1:0] cnt_r; // wait counter
    wire [DW-1:0] dq_sync; // data after two flops

    // one step down a wait counter, saturating at zero so a stray
    // entry with an empty counter cannot wrap to a long wait
    function [`ASC_CNT_W-1:0] cnt_dec;
        input [`ASC_CNT_W-1:0] c;
        begin
            if (c == `ASC_CNT_ZERO)
                cnt_dec = `ASC_CNT_ZERO;
            else
                cnt_dec = c - `ASC_CNT_ONE;
        end
    endfunction

    // returning data crosses in from the pins
    asc_sync #(.W(DW)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d_in(mem_dq_in),
        .d_out(dq_sync)
    );

    // single sequencer; every pin comes from a flop
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_r <= S_IDLE;
            cnt_r <= `ASC_CNT_ZERO;
            req_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= {DW{1'b0}};
            mem_addr <= {AW{1'b0}};
            // pins parked: deselected, strobes high, bus released
            active_low_select_n <= 1'b1; // deselected
            active_high_select <= 1'b0;
            mem_we_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_dq_out <= {DW{1'b0}};
            mem_dq_oe <= 1'b0;
        end
        else
        begin
            rd_valid <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    // deselected here, so address may move
                    req_ready <= 1'b1; // offered from the cycle after
                    // taken only when ready was already shown
                    if (req_valid && req_ready)
                    begin
                        // accept: ready drops for the whole access
                        req_ready <= 1'b0;
                        mem_addr <= req_addr;
                        if (req_write)
                        begin
                            // data set up now, driven once selected
                            mem_dq_out <= req_wdata;
                            mem_oe_n <= 1'b1;
                            state_r <= S_WSEL;
                        end
                        else
                        begin
                            // both selects together, strobe high
                            active_low_select_n <= 1'b0;
                            active_high_select <= 1'b1;
                            mem_we_n <= 1'b1;
                            mem_oe_n <= 1'b0;
                            cnt_r <= RD_CYC;
                            state_r <= S_RSEL;
                        end
                    end
                end
                S_RSEL:
                begin
                    // wait out access time plus sync delay
                    if (cnt_r == `ASC_CNT_ZERO)
                    begin
                        // sampled data has settled through both flops
                        state_r <= S_RCAP;
                    end
                    else
                    begin
                        // selects and oe stay put while counting
                        cnt_r <= cnt_dec(cnt_r);
                    end
                end
                S_RCAP:
                begin
                    // take the byte, then drop both selects and oe
                    rd_data <= dq_sync;
                    rd_valid <= 1'b1; // one-cycle strobe to the user
                    active_low_select_n <= 1'b1;
                    active_high_select <= 1'b0;
                    mem_oe_n <= 1'b1; // bus free before any write
                    // address may move next cycle, selects are off
                    state_r <= S_IDLE;
                end
                S_WSEL:
                begin
                    // select and strobe fall together: outputs stay off
                    active_low_select_n <= 1'b0;
                    active_high_select <= 1'b1;
                    mem_we_n <= 1'b0;
                    // memory output never turned on, so drive at once
                    mem_dq_oe <= 1'b1; // oe high, memory never drove
                    cnt_r <= WP_CYC;
                    state_r <= S_WPUL;
                end
                S_WPUL:
                begin
                    // pulse covers twp; data overlap satisfied inside it
                    if (cnt_r == `ASC_CNT_ONE)
                    begin
                        // strobe and low select rise together, ending
                        // the write before any other pin moves
                        mem_we_n <= 1'b1;
                        active_low_select_n <= 1'b1;
                        cnt_r <= WR_CYC;
                        state_r <= S_WEND;
                    end
                    else
                    begin
                        // longer pulses only if twp grows past a clock
                        cnt_r <= cnt_dec(cnt_r);
                    end
                end
                S_WEND:
                begin
                    // drop the high select; with WR_CYC of one, data is released on the same edge
                    active_high_select <= 1'b0;
                    if (cnt_r <= `ASC_CNT_ONE)
                    begin
                        // data released with the write already closed
                        mem_dq_oe <= 1'b0; // no drive back
                        state_r <= S_IDLE;
                    end
                    else
                    begin
                        // keep data on the bus for the recovery time
                        cnt_r <= cnt_dec(cnt_r);
                    end
                end
                default:
                begin
                    // stray code: park selects, strobes and data drive idle before returning; address is left as it was
                    active_low_select_n <= 1'b1;
                    active_high_select <= 1'b0;
                    mem_we_n <= 1'b1;
                    mem_oe_n <= 1'b1;
                    mem_dq_oe <= 1'b0;
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule // asc_ctrl

// file: asc_ctrl_assertions.sv
// pin-level checks on the memory side of the controller and on request-to-answer latency
module asc_chk (
    // clock, reset and request side
    input wire clk_sys, rst, req_valid, req_write, req_ready, rd_valid,
    // memory pins
    input wire [12:0] mem_addr,
    input wire active_low_select_n, active_high_select,
    input wire mem_we_n, mem_oe_n, mem_dq_oe
);
    wire sel_on = !active_low_select_n && active_high_select;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_read_no_we: assert property (!mem_oe_n |-> mem_we_n)
        else $error("strobe low while output enabled");
    a_addr_hold: assert property (sel_on && !mem_we_n |=> $stable(mem_addr))
        else $error("address moved during write");
    a_no_clash: assert property (mem_dq_oe |-> mem_oe_n)
        else $error("host drives while memory enabled");
    a_pulse_len: assert property ($fell(mem_we_n) |=> mem_we_n)
        else $error("strobe pulse not one cycle");
    a_sel_pair: assert property (!active_low_select_n |-> active_high_select)
        else $error("low select without high select");
    a_we_sel: assert property (!mem_we_n |-> sel_on && mem_dq_oe)
        else $error("strobe low without select or data");
    a_rd_lat: assert property (req_valid && req_ready && !req_write |-> ##[5:6] rd_valid)
        else $error("read answer late");
    a_wr_start: assert property (req_valid && req_ready && req_write |-> ##[1:2] !mem_we_n)
        else $error("write strobe missing");
endmodule // asc_chk
bind asc_ctrl asc_chk u_chk (.clk_sys(clk_sys), .rst(rst),
    .req_valid(req_valid), .req_write(req_write), .req_ready(req_ready),
    .rd_valid(rd_valid), .mem_addr(mem_addr), .mem_we_n(mem_we_n),
    .active_low_select_n(active_low_select_n), .mem_oe_n(mem_oe_n),
    .active_high_select(active_high_select), .mem_dq_oe(mem_dq_oe));

// file: asc_mem_model.sv
// behavioural byte-wide static memory, no clock
module asc_mem_model (
    // pins from the controller
    input wire [12:0] addr,
    input wire sel_n, sel, we_n, oe_n, host_oe,
    input wire [7:0] dq_host,
    // data back to the controller
    output wire [7:0] dq_mem
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:8191];
    logic [7:0] last = 8'h00;
    wire sel_on = !sel_n && sel;
    // drives only when selected, enabled and not writing
    wire drive = sel_on && we_n && !oe_n;
    // write follows the overlap of strobe and selects
    always @*
        if (sel_on && !we_n)
            mem[addr] = host_oe ? dq_host : ~last;
    // floating bus shows the inverse of the last byte, never a stale copy
    always @*
        if (drive)
            last = mem[addr];
    assign dq_mem = drive ? mem[addr] : ~last;
endmodule // asc_mem_model

// file: testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rst = 1, req_valid = 0, req_write = 0;
    logic [12:0] req_addr = 13'h0000;
    logic [7:0] req_wdata = 8'h00;
    wire req_ready, rd_valid, sel_n, sel, we_n, oe_n, dq_oe;
    wire [7:0] rd_data, dq_in, dq_out;
    wire [12:0] mem_addr;
    int err_total = 0;
    int n_tests = 0;
    always #25 clk_sys = ~clk_sys;
    asc_ctrl dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .mem_addr(mem_addr), .active_low_select_n(sel_n),
        .active_high_select(sel), .mem_we_n(we_n), .mem_oe_n(oe_n),
        .mem_dq_in(dq_in), .mem_dq_out(dq_out), .mem_dq_oe(dq_oe));
    asc_mem_model u_mem (.addr(mem_addr), .sel_n(sel_n), .sel(sel),
        .we_n(we_n), .oe_n(oe_n), .host_oe(dq_oe), .dq_host(dq_out),
        .dq_mem(dq_in));
    // one compare for every kind of value
    task chk(string nm, logic [12:0] e, logic [12:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task end_sim;
        $display("mismatches %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one access; a read compares against d
    task access(logic w, logic [12:0] a, logic [7:0] d);
        int i;
        i = 0;
        while (req_ready !== 1'b1 && i < 50)
        begin
            @(negedge clk_sys);
            i++;
        end
        if (req_ready !== 1'b1)
        begin
            chk("ready timeout", 13'h0000, 13'h0001);
            end_sim();
        end
        req_valid = 1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(negedge clk_sys);
        req_valid = 0;
        chk("mem_addr", a, mem_addr);
        chk("oe_n", {12'h000, w}, {12'h000, oe_n});
        if (w)
            chk("dq_out", {5'h00, d}, {5'h00, dq_out});
        i = 0;
        while (!w && rd_valid !== 1'b1 && i < 20)
        begin
            @(negedge clk_sys);
            i++;
        end
        if (!w && rd_valid !== 1'b1)
        begin
            chk("rd timeout", 13'h0000, 13'h0001);
            end_sim();
        end
        if (!w)
            chk("rd_data", {5'h00, d}, {5'h00, rd_data});
    endtask
    // pins idle while reset is held
    task t_reset;
        chk("idle pins", 13'h001a, {7'h00, req_ready, rd_valid, oe_n,
            sel_n, sel, we_n, dq_oe});
    endtask
    // both ends of the address range, back to back
    task t_bounds;
        access(1, 13'h0000, 8'ha5);
        access(1, 13'h1fff, 8'h5a);
        access(0, 13'h0000, 8'ha5);
        access(0, 13'h1fff, 8'h5a);
    endtask
    // overwrite leaves the neighbour alone
    task t_overwrite;
        access(1, 13'h0001, 8'h0f);
        access(1, 13'h0001, 8'hf0);
        access(0, 13'h0001, 8'hf0);
        access(0, 13'h0000, 8'ha5);
    endtask
    initial
    begin
        repeat (6) @(negedge clk_sys);
        t_reset();
        repeat (6) @(negedge clk_sys);
        rst = 0;
        t_bounds();
        t_overwrite();
        end_sim();
    end
endmodule // testbench
